// file: adcc_pkg.sv
// adcc_pkg: constants, register map and timing tables of the converter control block
package adcc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADCC_RES_W = 10;
  localparam int ADCC_CH_N = 4;
  localparam int ADCC_CNT_W = 8;
  localparam int ADCC_BIT_W = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADCC_MODE_ADDR = 16'hff80;
  localparam logic [15:0] ADCC_CHSEL_ADDR = 16'hff81;
  localparam logic [15:0] ADCC_RES_LO_ADDR = 16'hff18;
  localparam logic [15:0] ADCC_RES_HI_ADDR = 16'hff19;
  localparam logic [15:0] ADCC_RESH_ADDR = 16'hff1a;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int ADCC_RUN_BIT = 7;
  localparam int ADCC_TSEL_LSB = 3;
  localparam int ADCC_TSEL_MSB = 5;
  localparam int ADCC_REFEN_BIT = 0;
  localparam logic [7:0] ADCC_MODE_MASK = 8'hb9;
  localparam logic [7:0] ADCC_CHSEL_MASK = 8'h03;
  localparam logic [7:0] ADCC_MODE_RST = 8'h00;
  localparam logic [7:0] ADCC_CHSEL_RST = 8'h00;
  localparam logic [ADCC_RES_W-1:0] ADCC_SAR_MSB = 10'h200;
  localparam logic [ADCC_BIT_W-1:0] ADCC_TOP_BIT = 4'h9;
  localparam logic [ADCC_CNT_W-1:0] ADCC_CNT_ONE = 8'h01;
  localparam logic [2:0] ADCC_STEP_ONE = 3'h1;

  // ----------------------------------------------------------------
  // timing tables in peripheral-clock cycles
  // ----------------------------------------------------------------
  function automatic logic [ADCC_CNT_W-1:0] adcc_sample_cycles(input logic [2:0] code);
    logic [ADCC_CNT_W-1:0] n;
    n = 8'h0c;
    case (code)
      3'h0: n = 8'h0c;
      3'h1: n = 8'h18;
      3'h2: n = 8'h30;
      3'h3: n = 8'h58;
      3'h4: n = 8'h18;
      3'h5: n = 8'h30;
      3'h6: n = 8'h60;
      default: n = 8'hb0;
    endcase
    return n;
  endfunction

  function automatic logic [ADCC_CNT_W-1:0] adcc_total_cycles(input logic [2:0] code);
    logic [ADCC_CNT_W-1:0] n;
    n = 8'h24;
    case (code)
      3'h0: n = 8'h24;
      3'h1: n = 8'h30;
      3'h2: n = 8'h48;
      3'h3: n = 8'h70;
      3'h4: n = 8'h48;
      3'h5: n = 8'h60;
      3'h6: n = 8'h90;
      default: n = 8'he0;
    endcase
    return n;
  endfunction

  // cycles per bit decision: (total - sample) / 10, rounded down
  function automatic logic [2:0] adcc_step_cycles(input logic [2:0] code);
    return code[2] ? 3'h4 : 3'h2;
  endfunction

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_SAMPLE,
    ADCC_CONVERT,
    ADCC_FINISH
  } adcc_state_t;

endpackage

// file: adcc_sar_if.sv
// adcc_sar_if: handshake between the conversion sequencer and the approximation register
`timescale 1ns/10ps
`default_nettype none
interface adcc_sar_if;
  logic load_msb;
  logic decide;
  logic cmp_high;
  logic [9:0] code;
  logic last_bit;

  modport seq (
    output load_msb,
    output decide,
    output cmp_high,
    input code,
    input last_bit
  );

  modport sar (
    input load_msb,
    input decide,
    input cmp_high,
    output code,
    output last_bit
  );
endinterface
`default_nettype wire

// file: adcc_sar_reg.sv
// adcc_sar_reg: successive-approximation register, one bit per decision
`timescale 1ns/10ps
`default_nettype none
module adcc_sar_reg
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sequencer side
  adcc_sar_if.sar sar_if
);
  import adcc_pkg::*;

  logic [ADCC_RES_W-1:0] approx_q;
  logic [ADCC_RES_W-1:0] approx_d;
  logic [ADCC_BIT_W-1:0] bit_q;
  logic [ADCC_BIT_W-1:0] bit_d;
  logic [ADCC_RES_W-1:0] cur_mask;
  logic [ADCC_RES_W-1:0] next_mask;
  logic [ADCC_RES_W-1:0] kept;

  // ----------------------------------------------------------------
  // bit decision
  // ----------------------------------------------------------------
  assign cur_mask = ADCC_SAR_MSB >> (ADCC_TOP_BIT - bit_q);
  assign next_mask = cur_mask >> 1;
  assign kept = sar_if.cmp_high ? approx_q : (approx_q & ~cur_mask);
  assign sar_if.last_bit = (bit_q == '0);
  assign sar_if.code = approx_q;

  always_comb
  begin
    approx_d = approx_q;
    bit_d = bit_q;
    if (sar_if.load_msb)
    begin
      approx_d = ADCC_SAR_MSB;
      bit_d = ADCC_TOP_BIT;
    end
    else if (sar_if.decide)
    begin
      approx_d = kept | next_mask;
      if (bit_q != '0)
      begin
        bit_d = bit_q - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      approx_q <= '0;
      bit_q <= ADCC_TOP_BIT;
    end
    else
    begin
      approx_q <= approx_d;
      bit_q <= bit_d;
    end
  end
endmodule
`default_nettype wire

// file: adcc_top.sv
// adcc_top: registers and conversion sequencing of the 10-bit converter control block
//
// Function
// - four analog inputs; unselected input pins stay usable as port inputs
// - sample selected input at conversion start, hold it for the whole conversion
// - resolve bits MSB first; copy register to results after LSB
// - wide result gets 10-bit value, upper six bits read zero
// - high result register loaded with upper eight result bits
// - raise end-of-conversion interrupt after every finished conversion
// - mode register at FF80H, reset 00H, run/timing/reference layout
// - run bit zero stops conversion, one enables it
// - timing field picks sampling and total cycle counts from table
// - reference enable bit switches reference generator off or on
// - conversion proceeds without reference; first result invalid, software discards
// - run/reference bits give stop, waiting and conversion states
// - mode register accepts single-bit and byte writes
// - channel register accepts bit and byte writes, resets to 00H
// - two low channel bits choose input channel 0 to 3
// - conversions repeat back to back until run bit is cleared
// - mode or channel write aborts conversion; restarts if run set
// - each step sets next bit, keeps or clears it by comparator
// - high result register shows top eight bits of the result
`timescale 1ns/10ps
`default_nettype none
module adcc_top
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // processor register port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wmask,
  input wire logic [7:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  // analog front end
  input wire logic cmp_in,
  output logic sample_en,
  output logic [ADCC_CH_N-1:0] analog_input_sel,
  output logic [ADCC_CH_N-1:0] port_input_avail,
  output logic [ADCC_RES_W-1:0] tap_code,
  output logic ref_gen_on,
  // status and interrupt
  output logic [1:0] op_state,
  output logic conversion_done_irq
);
  import adcc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] chsel_q;
  logic [7:0] chsel_d;
  logic [ADCC_RES_W-1:0] result_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic cmp_q;
  logic irq_q;
  logic sample_q;
  adcc_state_t state_q;
  adcc_state_t state_d;
  logic [ADCC_CNT_W-1:0] cnt_q;
  logic [ADCC_CNT_W-1:0] cnt_d;
  logic [2:0] step_q;
  logic [2:0] step_d;
  logic sel_mode;
  logic sel_chsel;
  logic sel_res_lo;
  logic sel_res_hi;
  logic sel_resh;
  logic wr_mode;
  logic wr_chsel;
  logic restart;
  logic run;
  logic ref_en;
  logic [2:0] tsel;
  logic [ADCC_CNT_W-1:0] sample_last;
  logic [ADCC_CNT_W-1:0] total_last;
  logic [2:0] step_last;
  logic sample_end;
  logic step_end;
  logic conv_end;
  logic latch_result;
  logic [15:0] result_wide;
  logic [7:0] result_high;

  adcc_sar_if sar_bus ();

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign sel_mode = (cpu_addr == ADCC_MODE_ADDR);
  assign sel_chsel = (cpu_addr == ADCC_CHSEL_ADDR);
  assign sel_res_lo = (cpu_addr == ADCC_RES_LO_ADDR);
  assign sel_res_hi = (cpu_addr == ADCC_RES_HI_ADDR);
  assign sel_resh = (cpu_addr == ADCC_RESH_ADDR);
  assign wr_mode = cpu_wr && sel_mode;
  assign wr_chsel = cpu_wr && sel_chsel;
  assign restart = wr_mode || wr_chsel;

  // masked write covers both single-bit and whole-byte stores
  assign mode_d = wr_mode
    ? (((mode_q & ~cpu_wmask) | (cpu_wdata & cpu_wmask)) & ADCC_MODE_MASK)
    : mode_q;
  assign chsel_d = wr_chsel
    ? (((chsel_q & ~cpu_wmask) | (cpu_wdata & cpu_wmask)) & ADCC_CHSEL_MASK)
    : chsel_q;

  assign run = mode_q[ADCC_RUN_BIT];
  assign ref_en = mode_q[ADCC_REFEN_BIT];
  assign tsel = mode_q[ADCC_TSEL_MSB:ADCC_TSEL_LSB];

  // ----------------------------------------------------------------
  // result views and read data
  // ----------------------------------------------------------------
  assign result_wide = {6'h00, result_q};
  assign result_high = result_q[ADCC_RES_W-1:2];

  // results have no write path at all
  always_comb
  begin
    rdata_d = 16'h0000;
    if (sel_mode)
    begin
      rdata_d = {8'h00, mode_q};
    end
    else if (sel_chsel)
    begin
      rdata_d = {8'h00, chsel_q};
    end
    else if (sel_res_lo)
    begin
      rdata_d = result_wide;
    end
    else if (sel_res_hi)
    begin
      rdata_d = {8'h00, result_wide[15:8]};
    end
    else if (sel_resh)
    begin
      rdata_d = {8'h00, result_high};
    end
  end

  // ----------------------------------------------------------------
  // sequencing: sample, bit steps, pad to total length
  // ----------------------------------------------------------------
  assign sample_last = adcc_sample_cycles(tsel) - ADCC_CNT_ONE;
  assign total_last = adcc_total_cycles(tsel) - ADCC_CNT_ONE;
  assign step_last = adcc_step_cycles(tsel) - ADCC_STEP_ONE;
  assign sample_end = (state_q == ADCC_SAMPLE) && (cnt_q == sample_last);
  assign step_end = (state_q == ADCC_CONVERT) && (step_q == step_last);
  assign conv_end = (state_q == ADCC_FINISH) && (cnt_q == total_last);
  assign latch_result = conv_end && !restart;

  assign sar_bus.load_msb = sample_end;
  assign sar_bus.decide = step_end;
  assign sar_bus.cmp_high = cmp_q;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q + ADCC_CNT_ONE;
    step_d = '0;
    case (state_q)
      ADCC_IDLE:
      begin
        cnt_d = '0;
        // reference state does not gate the conversion
        if (run)
        begin
          state_d = ADCC_SAMPLE;
        end
      end
      ADCC_SAMPLE:
      begin
        if (sample_end)
        begin
          state_d = ADCC_CONVERT;
        end
      end
      ADCC_CONVERT:
      begin
        step_d = step_q + ADCC_STEP_ONE;
        if (step_end)
        begin
          step_d = '0;
          if (sar_bus.last_bit)
          begin
            state_d = ADCC_FINISH;
          end
        end
      end
      ADCC_FINISH:
      begin
        if (conv_end)
        begin
          cnt_d = '0;
          state_d = run ? ADCC_SAMPLE : ADCC_IDLE;
        end
      end
      default:
      begin
        state_d = ADCC_IDLE;
      end
    endcase
    if (restart)
    begin
      state_d = ADCC_IDLE;
      cnt_d = '0;
      step_d = '0;
    end
  end

  // ----------------------------------------------------------------
  // front-end outputs
  // ----------------------------------------------------------------
  assign analog_input_sel = 4'h1 << chsel_q[1:0];
  assign port_input_avail = ~analog_input_sel;
  assign sample_en = sample_q;
  assign tap_code = sar_bus.code;
  assign ref_gen_on = ref_en;
  assign op_state = {run, ref_en && !run};
  assign conversion_done_irq = irq_q;
  assign cpu_rdata = rdata_q;

  adcc_sar_reg u_sar (
    .mclk(mclk),
    .rst(rst),
    .sar_if(sar_bus)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= ADCC_MODE_RST;
      chsel_q <= ADCC_CHSEL_RST;
      rdata_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      chsel_q <= chsel_d;
      rdata_q <= rdata_d;
    end
  end

  // comparator is strobed by the converter on mclk, no resynchronising;
  // a single stage keeps each decision inside a bit step of two or four cycles
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cmp_q <= 1'b0;
    end
    else
    begin
      cmp_q <= cmp_in;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ADCC_IDLE;
      cnt_q <= '0;
      step_q <= '0;
      sample_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      sample_q <= (state_d == ADCC_SAMPLE);
      irq_q <= latch_result;
    end
  end

  // result holds its power-up value until the first conversion ends
  always_ff @(posedge mclk)
  begin
    if (latch_result)
    begin
      result_q <= sar_bus.code;
    end
  end
endmodule
`default_nettype wire

// file: adcc_top_asserts.sv
// adcc_top_asserts: port-level assertions of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_top_asserts
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // processor register port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wmask,
  input wire logic [7:0] cpu_wdata,
  input wire logic [15:0] cpu_rdata,
  // analog front end
  input wire logic cmp_in,
  input wire logic sample_en,
  input wire logic [ADCC_CH_N-1:0] analog_input_sel,
  input wire logic [ADCC_CH_N-1:0] port_input_avail,
  input wire logic [ADCC_RES_W-1:0] tap_code,
  input wire logic ref_gen_on,
  // status and interrupt
  input wire logic [1:0] op_state,
  input wire logic conversion_done_irq
);
  import adcc_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_irq_one_cycle: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("end-of-conversion pulse longer than one cycle");
  a_pins_free_inverse: assert property (port_input_avail == ~analog_input_sel)
    else $error("free port pins do not mirror the selected channel");
  a_sel_one_hot: assert property ($onehot(analog_input_sel))
    else $error("channel select not one-hot");
  a_sel_follows_write: assert property (cpu_wr && cpu_addr == ADCC_CHSEL_ADDR &&
    cpu_wmask == 8'hff |=> analog_input_sel == 4'(4'h1 << $past(cpu_wdata[1:0])))
    else $error("selected channel does not follow the written code");
  a_chsel_high_zero: assert property (cpu_addr == ADCC_CHSEL_ADDR |=> cpu_rdata[15:2] == 14'h0000)
    else $error("channel register upper bits not zero");
  a_ref_turns_on: assert property (cpu_wr && cpu_addr == ADCC_MODE_ADDR && cpu_wmask[0] &&
    cpu_wdata[0] |-> ##[1:2] ref_gen_on)
    else $error("reference generator not enabled after write");
  a_stopped_no_irq: assert property (!op_state[1] && !$past(op_state[1]) |-> !conversion_done_irq)
    else $error("conversion finished while stopped");
  a_msb_trial_first: assert property ($fell(sample_en) && !$past(cpu_wr) && !$past(cpu_wr, 2)
    |-> ##[0:2] tap_code == ADCC_SAR_MSB)
    else $error("first trial after sampling is not the top bit");
  a_sample_min_len: assert property ($rose(sample_en) && !cpu_wr && !$past(cpu_wr)
    ##1 (!cpu_wr)[*8] |-> sample_en)
    else $error("sampling phase ended too early");
  a_irq_restarts_sample: assert property (conversion_done_irq && op_state[1] |-> ##[0:2] sample_en)
    else $error("next conversion did not start after completion");
endmodule

bind adcc_top adcc_top_asserts i_chk (
  .mclk(mclk),
  .rst(rst),
  .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr),
  .cpu_wmask(cpu_wmask),
  .cpu_wdata(cpu_wdata),
  .cpu_rdata(cpu_rdata),
  .cmp_in(cmp_in),
  .sample_en(sample_en),
  .analog_input_sel(analog_input_sel),
  .port_input_avail(port_input_avail),
  .tap_code(tap_code),
  .ref_gen_on(ref_gen_on),
  .op_state(op_state),
  .conversion_done_irq(conversion_done_irq)
);
`default_nettype wire

// file: adcc_analog_model.sv
// adcc_analog_model: behavioural sample-and-hold, resistor string and comparator
`timescale 1ns/10ps
`default_nettype none
module adcc_analog_model
  import adcc_pkg::*;
#(
  parameter logic [39:0] VIN = 40'h00_0000_0000
)
(
  input wire logic mclk,
  input wire logic sample_en,
  input wire logic [ADCC_CH_N-1:0] analog_input_sel,
  input wire logic [ADCC_RES_W-1:0] tap_code,
  output logic cmp_in
);
  import adcc_pkg::*;
  logic [ADCC_RES_W-1:0] held_q;
  // track the selected pin, freeze while holding
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < ADCC_CH_N; i++)
      if (sample_en && analog_input_sel[i])
        held_q <= VIN[i*ADCC_RES_W +: ADCC_RES_W];
  end
  assign cmp_in = (held_q >= tap_code);
endmodule
`default_nettype wire

// file: sar_adc_control_registers_bench.sv
// sar_adc_control_registers_bench: register-level testbench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_registers_bench;
  import adcc_pkg::*;
  localparam logic [39:0] VIN = {10'h000, 10'h3ff, 10'h15a, 10'h2a5};
  localparam int SAM [8] = '{12, 24, 48, 88, 24, 48, 96, 176};
  localparam int TOT [8] = '{36, 48, 72, 112, 72, 96, 144, 224};
  logic mclk, rst, cpu_wr, cmp_in, sample_en, ref_gen_on, conversion_done_irq;
  logic [15:0] cpu_addr, cpu_rdata;
  logic [7:0] cpu_wmask, cpu_wdata;
  logic [ADCC_CH_N-1:0] analog_input_sel, port_input_avail;
  logic [ADCC_RES_W-1:0] tap_code, v;
  logic [1:0] op_state;
  int error_cnt, cmp_count, n, s;

  adcc_top i_dut (.mclk(mclk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_wmask(cpu_wmask), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cmp_in(cmp_in),
    .sample_en(sample_en), .analog_input_sel(analog_input_sel),
    .port_input_avail(port_input_avail), .tap_code(tap_code), .ref_gen_on(ref_gen_on),
    .op_state(op_state), .conversion_done_irq(conversion_done_irq));
  adcc_analog_model #(.VIN(VIN)) i_model (.mclk(mclk), .sample_en(sample_en),
    .analog_input_sel(analog_input_sel), .tap_code(tap_code), .cmp_in(cmp_in));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] m, input logic [7:0] d);
    @(negedge mclk);
    cpu_addr = a;
    cpu_wmask = m;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge mclk);
    cpu_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(negedge mclk);
    cpu_addr = a;
    @(negedge mclk);
    chk(cpu_rdata, exp, what);
  endtask

  // cycles to next completion in n, sampling cycles in s
  task automatic wait_irq(input int max);
    n = 0;
    s = 0;
    do
    begin
      @(negedge mclk);
      n++;
      s += int'(sample_en === 1'b1);
    end while (conversion_done_irq !== 1'b1 && n < max);
    if (conversion_done_irq !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: no end of conversion", $time);
      results();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    cpu_addr = 16'h0000;
    cpu_wr = 1'b0;
    cpu_wmask = 8'h00;
    cpu_wdata = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    rd(ADCC_MODE_ADDR, 16'h0000, "mode reset");
    rd(ADCC_CHSEL_ADDR, 16'h0000, "channel reset");
    chk(16'(op_state), 16'h0000, "stopped");
    wr(ADCC_MODE_ADDR, 8'hff, 8'h7e);
    rd(ADCC_MODE_ADDR, 16'h0038, "mode layout");
    wr(ADCC_MODE_ADDR, 8'hff, 8'h00);
    wr(ADCC_MODE_ADDR, 8'h01, 8'hff);
    rd(ADCC_MODE_ADDR, 16'h0001, "mode bit write");
    chk(16'(op_state), 16'h0001, "waiting");
    chk(16'(ref_gen_on), 16'h0001, "reference on");
    wr(ADCC_CHSEL_ADDR, 8'h02, 8'hff);
    rd(ADCC_CHSEL_ADDR, 16'h0002, "channel bit write");
    chk(16'(analog_input_sel), 16'h0004, "selected pin");
    repeat (25) @(negedge mclk); // reference settles
    for (int c = 0; c < ADCC_CH_N; c++)
    begin
      v = VIN[c*ADCC_RES_W +: ADCC_RES_W];
      wr(ADCC_CHSEL_ADDR, 8'hff, 8'(c));
      chk(16'(port_input_avail), 16'(4'hf ^ (4'h1 << c)), "free pins");
      wr(ADCC_MODE_ADDR, 8'hff, 8'h81);
      wait_irq(300);
      wait_irq(300);
      rd(ADCC_RES_LO_ADDR, {6'h00, v}, "wide result");
      rd(ADCC_RES_HI_ADDR, {14'h0000, v[9:8]}, "wide upper byte");
      rd(ADCC_RESH_ADDR, {8'h00, v[9:2]}, "high result");
      wr(ADCC_MODE_ADDR, 8'hff, 8'h01);
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(ADCC_MODE_ADDR, 8'hff, 8'(8'h81 | (c << 3))); // stopped before retiming
      wait_irq(300);
      wait_irq(300);
      chk(16'(n >= TOT[c] && n <= TOT[c] + 1), 16'h0001, "period");
      chk(16'(s >= SAM[c] - 1 && s <= SAM[c] + 1), 16'h0001, "sample length");
      wr(ADCC_MODE_ADDR, 8'hff, 8'h01);
    end
    wr(ADCC_CHSEL_ADDR, 8'hff, 8'h00);
    wr(ADCC_MODE_ADDR, 8'hff, 8'h81);
    wait_irq(300);
    repeat (20) @(negedge mclk);
    wr(ADCC_CHSEL_ADDR, 8'hff, 8'h01);
    wait_irq(300);
    chk(16'(n >= 36), 16'h0001, "restart after abort");
    rd(ADCC_RES_LO_ADDR, {6'h00, VIN[19:10]}, "restarted result");
    wr(ADCC_RESH_ADDR, 8'hff, 8'h5a);
    rd(ADCC_RESH_ADDR, {8'h00, VIN[19:12]}, "result read-only");
    rd(16'hff7f, 16'h0000, "unmapped read");
    wr(ADCC_MODE_ADDR, 8'h80, 8'h00);
    chk(16'(op_state), 16'h0001, "back to waiting");
    n = 0;
    repeat (300)
    begin
      @(negedge mclk);
      n += int'(conversion_done_irq !== 1'b0);
    end
    chk(16'(n), 16'h0000, "no completion while stopped");
    wr(ADCC_MODE_ADDR, 8'hff, 8'h80);
    chk(16'(op_state[1]), 16'h0001, "converting without reference");
    wait_irq(300);
    chk(16'(ref_gen_on), 16'h0000, "reference off");
    wr(ADCC_MODE_ADDR, 8'hff, 8'h00);
    chk(16'(op_state), 16'h0000, "fully stopped");
    results();
  end
endmodule
`default_nettype wire
